// file: src/rtc_flags_ctrl.sv
// Flags and control register of the real-time clock, APB slave
// Function
// (RQ1) The watchdog flag is set when the watchdog runs down to zero unreloaded, and software cannot write it.
// (RQ2) The watchdog flag clears on any read of the flags register and at power-up.
// (RQ3) At power-up the oscillator fail flag is set if the oscillator is enabled but not running after 5 ms.
// (RQ4) The oscillator fail flag is never cleared by the block itself; the host clears it by writing zero.
// (RQ5) A zero written to the oscillator fail flag takes effect only after the update delay.
// (RQ6) While the calibration bit is one, the interrupt pin carries a 512 Hz square wave.
// (RQ7) The calibration bit resets to zero, and then the interrupt pin carries the normal interrupt.
// (RQ8) While write hold is one, timekeeping updates stop and host writes are accepted.
// (RQ9) Clearing write hold copies the registers into the counters only if the time changed, within the update delay.
// (RQ10) Write hold resets to zero at power-up.
// (RQ11) While read hold is one, clock updates to the holding registers stop; clearing it resumes them.
// (RQ12) The flags register holds watchdog, alarm, power fail, oscillator fail, a zero, calibration, write and read hold from bit 7 down.
//
// The register addresses and register access over APB are this design's own decisions.
`include "rtc_flags_params.svh"
`timescale 1ns/1ns
`default_nettype none

module rtc_flags_ctrl
  import rtc_flags_pkg::*;
#(
  parameter int STARTUP_CYC  = `STARTUP_CYC,
  parameter int UPDATE_CYC   = `UPDATE_DELAY_CYC,
  parameter int CAL_HALF_CYC = `CAL_HALF_CYC
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        wdog_expire,
  input  wire logic        alarm_match,
  input  wire logic        power_fail,
  input  wire logic        osc_enable,
  input  wire logic        osc_running,
  input  wire logic        time_written,
  output logic             timekeep_freeze,
  output logic             holding_freeze,
  output logic             load_counters,
  output logic             update_busy,
  output logic             int_pin,
  output logic             irq
);

  state_t s_q;
  state_t s_d;

  localparam logic [15:0] START_N = 16'(STARTUP_CYC);
  localparam logic [15:0] UPD_N   = 16'(UPDATE_CYC);
  localparam logic [15:0] CAL_N   = 16'(CAL_HALF_CYC);
  localparam logic [7:0]  FLAGS_RST = `FLAGS_RESET;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  logic       xfer;
  logic       rd_flags;
  logic       wr_flags;
  logic       wr_stat;
  logic       wr_mask;
  logic       mapped;
  logic [7:0] flags_v;
  logic [3:0] events;

  always_comb begin
    mapped   = hit(paddr, `OFS_FLAGS) || hit(paddr, `OFS_INT_STATUS) || hit(paddr, `OFS_INT_MASK);
    xfer     = psel && penable && s_q.ack;
    rd_flags = xfer && !pwrite && hit(paddr, `OFS_FLAGS);
    wr_flags = xfer && pwrite && hit(paddr, `OFS_FLAGS);
    wr_stat  = xfer && pwrite && hit(paddr, `OFS_INT_STATUS);
    wr_mask  = xfer && pwrite && hit(paddr, `OFS_INT_MASK);
    flags_v  = 8'h00;
    flags_v[`BIT_WDOG]     = s_q.wdog;  // [RQ12]
    flags_v[`BIT_ALARM]    = s_q.alarm;
    flags_v[`BIT_PWR_FAIL] = s_q.pwr_fail;
    flags_v[`BIT_OSC_FAIL] = s_q.osc_fail;
    flags_v[`BIT_CAL]      = s_q.cal;
    flags_v[`BIT_WHOLD]    = s_q.whold;
    flags_v[`BIT_RHOLD]    = s_q.rhold;
    events = {wdog_expire, alarm_match, power_fail, 1'b0};
  end

  always_comb begin
    s_d = s_q;
    s_d.copy = 1'b0;

    // Two-cycle access phase so read data comes straight from a flop
    s_d.ack = psel && penable && !s_q.ack;
    if (psel && penable && !s_q.ack) begin
      s_d.err   = !mapped;
      s_d.rdata = 32'h0000_0000;
      if (hit(paddr, `OFS_FLAGS)) begin
        s_d.rdata[7:0] = flags_v;
      end else if (hit(paddr, `OFS_INT_STATUS)) begin
        s_d.rdata[3:0] = s_q.int_status;
      end else if (hit(paddr, `OFS_INT_MASK)) begin
        s_d.rdata[3:0] = s_q.int_mask;
      end
    end

    // Read clears the event flags; an event in the same cycle wins
    if (rd_flags) begin
      s_d.wdog     = 1'b0;  // [RQ2]
      s_d.alarm    = 1'b0;
      s_d.pwr_fail = 1'b0;
    end
    if (wdog_expire) begin
      s_d.wdog = 1'b1;  // [RQ1]
    end
    if (alarm_match) begin
      s_d.alarm = 1'b1;
    end
    if (power_fail) begin
      s_d.pwr_fail = 1'b1;
    end

    // Oscillator pin: three flops, change taken once the last two agree
    s_d.osc_sync = {s_q.osc_sync[1:0], osc_running};
    if (s_q.osc_sync[1] == s_q.osc_sync[2]) begin
      s_d.osc_ok = s_q.osc_sync[2];
    end

    // Only a host zero (after the delay) or srst clears it; no other path clears it [RQ4]
    if (s_q.osc_clr_cnt != 16'h0000) begin
      s_d.osc_clr_cnt = s_q.osc_clr_cnt - 16'h0001;
      if (s_q.osc_clr_cnt == 16'h0001) begin
        s_d.osc_fail = 1'b0;  // [RQ5]
      end
    end

    // Placed after the clear so a startup failure in the same cycle wins
    if (!s_q.start_done) begin
      if (s_q.start_cnt >= START_N - 16'h0001) begin
        s_d.start_done = 1'b1;
        if (osc_enable && !s_q.osc_ok) begin
          s_d.osc_fail = 1'b1;  // [RQ3]
        end
      end else begin
        s_d.start_cnt = s_q.start_cnt + 16'h0001;
      end
    end

    if (s_q.whold && time_written) begin
      s_d.time_dirty = 1'b1;  // [RQ8]
    end
    if (s_q.upd_cnt != 16'h0000) begin
      s_d.upd_cnt = s_q.upd_cnt - 16'h0001;
    end

    if (wr_flags) begin
      s_d.cal   = pwdata[`BIT_CAL];
      s_d.whold = pwdata[`BIT_WHOLD];
      s_d.rhold = pwdata[`BIT_RHOLD];
      if (!pwdata[`BIT_OSC_FAIL] && s_q.osc_fail && s_q.osc_clr_cnt == 16'h0000) begin
        s_d.osc_clr_cnt = UPD_N;  // [RQ5]
      end
      if (s_q.whold && !pwdata[`BIT_WHOLD] && (s_q.time_dirty || time_written)) begin
        s_d.copy       = 1'b1;  // [RQ9]
        s_d.time_dirty = 1'b0;
        s_d.upd_cnt    = UPD_N;
      end
    end

    // Calibration wave runs only while selected
    if (s_q.cal) begin
      if (s_q.cal_cnt >= CAL_N - 16'h0001) begin
        s_d.cal_cnt  = 16'h0000;
        s_d.cal_wave = !s_q.cal_wave;  // [RQ6]
      end else begin
        s_d.cal_cnt = s_q.cal_cnt + 16'h0001;
      end
    end else begin
      s_d.cal_cnt  = 16'h0000;
      s_d.cal_wave = 1'b0;
    end

    if (wr_mask) begin
      s_d.int_mask = pwdata[3:0];
    end
    if (wr_stat) begin
      s_d.int_status = s_q.int_status & ~pwdata[3:0];
    end
    s_d.int_status = s_d.int_status | events;
    if (s_d.osc_fail && !s_q.osc_fail) begin
      s_d.int_status[0] = 1'b1;
    end

    if (srst) begin
      s_d            = '0;
      s_d.int_mask   = `INT_MASK_RESET;
      s_d.cal        = FLAGS_RST[`BIT_CAL];  // [RQ7]
      s_d.whold      = FLAGS_RST[`BIT_WHOLD];  // [RQ10]
      s_d.rhold      = FLAGS_RST[`BIT_RHOLD];
      s_d.wdog       = FLAGS_RST[`BIT_WDOG];  // [RQ2]
    end
  end

  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  always_comb begin
    pready          = psel && penable && s_q.ack;
    prdata          = s_q.rdata;
    pslverr         = pready && s_q.err;
    timekeep_freeze = s_q.whold;  // [RQ8]
    holding_freeze  = s_q.rhold;  // [RQ11]
    load_counters   = s_q.copy;
    update_busy     = s_q.upd_cnt != 16'h0000;
    irq             = |(s_q.int_status & s_q.int_mask);
    int_pin         = s_q.cal ? s_q.cal_wave : irq;  // [RQ6] [RQ7]
  end

  // Checks
  wdog_set_a: assert property (@(posedge clk) disable iff (srst)
    wdog_expire |=> s_q.wdog) else $error("watchdog flag not set");  // [RQ1]
  wdog_clr_a: assert property (@(posedge clk) disable iff (srst)
    rd_flags && !wdog_expire |=> !s_q.wdog) else $error("watchdog flag not cleared by read");  // [RQ2]
  osc_set_a: assert property (@(posedge clk) disable iff (srst)
    !s_q.start_done && s_d.start_done && osc_enable && !s_q.osc_ok |=> s_q.osc_fail)
    else $error("oscillator fail not set");  // [RQ3]
  osc_keep_a: assert property (@(posedge clk) disable iff (srst)
    s_q.osc_fail && s_q.osc_clr_cnt == 16'h0000 |=> s_q.osc_fail)
    else $error("oscillator fail cleared on its own");  // [RQ4]
  osc_delay_a: assert property (@(posedge clk) disable iff (srst)
    $rose(s_q.osc_clr_cnt != 16'h0000) |-> s_q.osc_fail [*2])
    else $error("oscillator fail cleared early");  // [RQ5]
  cal_pin_a: assert property (@(posedge clk) disable iff (srst)
    !s_q.cal |-> int_pin == irq) else $error("int pin not normal");  // [RQ7]
  cal_wave_a: assert property (@(posedge clk) disable iff (srst)
    s_q.cal && s_q.cal_cnt == 16'h0000 && $past(s_q.cal) |-> int_pin != $past(int_pin))
    else $error("calibration wave did not toggle");  // [RQ6]
  copy_a: assert property (@(posedge clk) disable iff (srst)
    load_counters |-> $past(s_q.whold) && !s_q.whold && update_busy)
    else $error("counter load without hold release");  // [RQ9]
  hold_out_a: assert property (@(posedge clk) disable iff (srst)
    wr_flags |=> timekeep_freeze == $past(pwdata[`BIT_WHOLD]) && holding_freeze == $past(pwdata[`BIT_RHOLD]))
    else $error("hold bits not taken");  // [RQ8] [RQ11]
  reset_a: assert property (@(posedge clk)
    srst |=> !s_q.cal && !s_q.whold && !s_q.wdog) else $error("reset values wrong");  // [RQ10]
  zero_bit_a: assert property (@(posedge clk) disable iff (srst)
    pready && !pwrite && paddr == `OFS_FLAGS |-> !prdata[`BIT_ZERO])
    else $error("flags bit 3 not zero");  // [RQ12]

  read_cov: cover property (@(posedge clk) disable iff (srst) rd_flags && s_q.wdog);
  copy_cov: cover property (@(posedge clk) disable iff (srst) load_counters);
  cal_cov: cover property (@(posedge clk) disable iff (srst) s_q.cal && $rose(s_q.cal_wave));
  osc_clr_cov: cover property (@(posedge clk) disable iff (srst) $fell(s_q.osc_fail));
  hold_cov: cover property (@(posedge clk) disable iff (srst) s_q.whold && time_written);

endmodule : rtc_flags_ctrl

`default_nettype wire

// file: src/rtc_flags_params.svh
// Constants for the flags and control register block
`ifndef RTC_FLAGS_PARAMS_SVH
`define RTC_FLAGS_PARAMS_SVH

`define CLK_PERIOD_NS      100
`define OFS_FLAGS          12'h000
`define OFS_INT_STATUS     12'h004
`define OFS_INT_MASK       12'h008
`define BIT_WDOG           7
`define BIT_ALARM          6
`define BIT_PWR_FAIL       5
`define BIT_OSC_FAIL       4
`define BIT_ZERO           3
`define BIT_CAL            2
`define BIT_WHOLD          1
`define BIT_RHOLD          0
`define FLAGS_RESET        8'h00
`define INT_MASK_RESET     4'h0
`define STARTUP_NS         5000000
`define UPDATE_DELAY_NS    350000
`define CAL_HALF_NS        976562
`define STARTUP_CYC        (`STARTUP_NS / `CLK_PERIOD_NS)
`define UPDATE_DELAY_CYC   (`UPDATE_DELAY_NS / `CLK_PERIOD_NS)
`define CAL_HALF_CYC       (`CAL_HALF_NS / `CLK_PERIOD_NS)

`endif

// file: src/rtc_flags_pkg.sv
// Types for the flags and control register block
package rtc_flags_pkg;
  typedef struct packed {
    logic        wdog;
    logic        alarm;
    logic        pwr_fail;
    logic        osc_fail;
    logic        cal;
    logic        whold;
    logic        rhold;
    logic        time_dirty;
    logic        copy;
    logic [15:0] upd_cnt;
    logic [15:0] osc_clr_cnt;
    logic [15:0] start_cnt;
    logic        start_done;
    logic [2:0]  osc_sync;
    logic        osc_ok;
    logic [15:0] cal_cnt;
    logic        cal_wave;
    logic [3:0]  int_status;
    logic [3:0]  int_mask;
    logic        ack;
    logic [31:0] rdata;
    logic        err;
  } state_t;
endpackage : rtc_flags_pkg

// file: tb/rtc_flags_ctrl_tb.sv
// Self-checking testbench for the flags and control register block
`timescale 1ns/1ns
`default_nettype none

module rtc_flags_ctrl_tb;
  // Short counts keep the run brief; the startup wait, update delay and calibration wave checks are derived from these
  localparam int STC  = 20;
  localparam int UPD  = 8;
  localparam int CALH = 4;
  logic        clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd, prdata;
  logic        wdog_expire = 1'b0, alarm_match = 1'b0, power_fail = 1'b0;
  logic        osc_enable = 1'b1, osc_running = 1'b0, time_written = 1'b0;
  logic        pready, pslverr, timekeep_freeze, holding_freeze, load_counters, update_busy, int_pin, irq, err;
  int          n_fail = 0, total_checks = 0;

  always #50 clk = ~clk;

  rtc_flags_ctrl #(.STARTUP_CYC(STC), .UPDATE_CYC(UPD), .CAL_HALF_CYC(CALH)) DUT (
    .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .wdog_expire(wdog_expire), .alarm_match(alarm_match), .power_fail(power_fail),
    .osc_enable(osc_enable), .osc_running(osc_running), .time_written(time_written),
    .timekeep_freeze(timekeep_freeze), .holding_freeze(holding_freeze),
    .load_counters(load_counters), .update_busy(update_busy), .int_pin(int_pin), .irq(irq));

  task conclude;
    $display("checks=%0d mismatches=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude

  task check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // Holds the request until pready is seen high at a rising edge, giving up after 20 cycles
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    check({31'h0, pready}, 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task t_reset;
    repeat (STC + 10) @(posedge clk);
    apb(1'b0, 12'h000, 32'h0); check(rd, 32'h10);
    check({30'h0, timekeep_freeze, holding_freeze}, 32'h0);
    check({31'h0, int_pin}, 32'h0);
    osc_running <= 1'b1;
  endtask : t_reset

  task t_events;
    apb(1'b1, 12'h000, 32'hf0); apb(1'b0, 12'h000, 32'h0); check(rd, 32'h10);
    @(posedge clk); wdog_expire <= 1'b1; alarm_match <= 1'b1; power_fail <= 1'b1;
    @(posedge clk); wdog_expire <= 1'b0; alarm_match <= 1'b0; power_fail <= 1'b0;
    apb(1'b0, 12'h000, 32'h0); check(rd, 32'hf0);
    apb(1'b0, 12'h000, 32'h0); check(rd, 32'h10);
    apb(1'b0, 12'h004, 32'h0); check(rd, 32'hf);
    check({31'h0, irq}, 32'h0);
    apb(1'b1, 12'h008, 32'h4); @(posedge clk); check({30'h0, irq, int_pin}, 32'h3);
    apb(1'b1, 12'h004, 32'h4); @(posedge clk); check({30'h0, irq, int_pin}, 32'h0);
    apb(1'b0, 12'h004, 32'h0); check(rd, 32'hb);
    apb(1'b1, 12'h004, 32'hf); apb(1'b1, 12'h008, 32'hf);
    apb(1'b0, 12'h00c, 32'h0); check({rd[30:0], err}, 32'h1);
  endtask : t_events

  task t_osc;
    // The zero lands only after the update delay, so an early read still sees it
    apb(1'b1, 12'h000, 32'h0); apb(1'b0, 12'h000, 32'h0); check(rd, 32'h10);
    repeat (UPD) @(posedge clk);
    apb(1'b0, 12'h000, 32'h0); check(rd, 32'h0);
  endtask : t_osc

  task t_cal;
    int   cnt;
    logic last;
    apb(1'b1, 12'h000, 32'h4);
    @(posedge clk);
    last = int_pin;
    cnt = 0;
    repeat (10 * CALH) begin
      @(posedge clk);
      if (int_pin !== last) cnt++;
      last = int_pin;
    end
    check({31'h0, cnt >= 9 && cnt <= 11}, 32'h1);
    apb(1'b1, 12'h000, 32'h0);
    @(posedge clk); alarm_match <= 1'b1;
    @(posedge clk); alarm_match <= 1'b0;
    repeat (CALH + 2) @(posedge clk);
    check({31'h0, int_pin}, 32'h1);
    apb(1'b0, 12'h000, 32'h0); apb(1'b1, 12'h004, 32'hf); @(posedge clk);
    check({31'h0, int_pin}, 32'h0);
  endtask : t_cal

  task t_hold;
    int n;
    apb(1'b1, 12'h000, 32'h2); @(posedge clk); check({31'h0, timekeep_freeze}, 32'h1);
    @(posedge clk); time_written <= 1'b1;
    @(posedge clk); time_written <= 1'b0;
    apb(1'b1, 12'h000, 32'h0);
    n = 0;
    while (load_counters !== 1'b1 && n < 4) begin
      @(posedge clk);
      n++;
    end
    check({31'h0, n < 4}, 32'h1);
    n = 0;
    while (update_busy === 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    check({31'h0, n >= UPD - 1 && n <= UPD + 1}, 32'h1);
    // Unchanged time must not reload the counters
    apb(1'b1, 12'h000, 32'h2); apb(1'b1, 12'h000, 32'h0);
    n = 0;
    repeat (6) begin
      @(posedge clk);
      if (load_counters === 1'b1) n++;
    end
    check(n, 32'h0);
    apb(1'b1, 12'h000, 32'h1); @(posedge clk);
    check({30'h0, timekeep_freeze, holding_freeze}, 32'h1);
    apb(1'b0, 12'h000, 32'h0); check(rd, 32'h1);
    apb(1'b1, 12'h000, 32'h0); @(posedge clk); check({31'h0, holding_freeze}, 32'h0);
  endtask : t_hold

  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    t_reset;
    t_events;
    t_osc;
    t_cal;
    t_hold;
    conclude;
  end

  // The whole sequence needs well under a thousand cycles
  initial begin
    repeat (4000) @(posedge clk);
    n_fail++;
    conclude;
  end
endmodule : rtc_flags_ctrl_tb

`default_nettype wire
